// ### bench/cpfs_core_monitor.sv
// Concurrent checks on the core's flow, flag and data-space ports
`include "cpfs_map.vh"
module cpfs_core_monitor (
    // Clock and reset
    input wire core_clk,
    input wire rstn,
    // Flow controls
    input wire fetch, branch, jump, call, ret, return_from_interrupt,
    input wire instr_boundary, irq_enter, nmi_enter,
    input wire [7:0] branch_offset,
    input wire [11:0] target,
    input wire [11:0] vector,
    // Flag, accumulator and data-space inputs
    input wire carry_we, carry_in, zero_we, acc_we, ds_rd, nmi_pin_n,
    input wire [7:0] alu_result,
    input wire [7:0] acc_in,
    // Observed state
    input wire ds_rvalid, nmi_request, carry_flag, zero_flag,
    input wire [11:0] pc,
    input wire [1:0] flag_mode,
    input wire [7:0] accumulator,
    input wire [2:0] stack_depth
);
    wire entry = instr_boundary && (irq_enter || nmi_enter);
    wire moves = entry || jump || call || branch || ret
        || return_from_interrupt;
    // Flag writes in a mode-switch cycle are left unjudged
    wire swap = entry || return_from_interrupt;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_pc_fetch_step: assert property (
        fetch && !moves |=> pc == $past(pc) + 12'h001)
        else $error("pc did not advance by one");
    a_pc_branch_sum: assert property (
        branch && !entry && !jump && !call |=> pc == $past(pc)
        + {{4{$past(branch_offset[7])}}, $past(branch_offset)})
        else $error("branch sum wrong");
    a_pc_jump_load: assert property (
        (jump || call) && !entry |=> pc == $past(target))
        else $error("jump target not loaded");
    a_entry_vector_mode: assert property (
        entry |=> pc == $past(vector) && flag_mode == ($past(nmi_enter)
        ? `CPFS_MODE_NMI : `CPFS_MODE_IRQ))
        else $error("entry vector or mode wrong");
    a_mode_hold: assert property (
        !swap |=> $stable(flag_mode))
        else $error("flag mode moved without entry or return");
    a_carry_write: assert property (
        carry_we && !swap |=> carry_flag == $past(carry_in))
        else $error("carry not written");
    a_zero_result: assert property (
        zero_we && !swap |=> zero_flag == ($past(alu_result) == 8'h00))
        else $error("zero flag wrong");
    a_acc_load: assert property (
        acc_we |=> accumulator == $past(acc_in))
        else $error("accumulator not loaded");
    a_read_latency: assert property (
        ds_rd |-> ##2 ds_rvalid)
        else $error("read answer missing");
    a_nmi_single: assert property (
        nmi_request |-> !$past(nmi_pin_n, 3) ##1 !nmi_request)
        else $error("nmi request not a single pulse after low pin");
    a_depth_limit: assert property (
        stack_depth <= 3'h6)
        else $error("stack depth beyond six");
endmodule
bind cpfs_core cpfs_core_monitor u_mon (
    .core_clk(core_clk), .rstn(rstn), .fetch(fetch), .branch(branch),
    .jump(jump), .call(call), .ret(ret),
    .return_from_interrupt(return_from_interrupt),
    .instr_boundary(instr_boundary), .irq_enter(irq_enter),
    .nmi_enter(nmi_enter), .branch_offset(branch_offset),
    .target(target), .vector(vector), .carry_we(carry_we),
    .carry_in(carry_in), .zero_we(zero_we), .acc_we(acc_we),
    .ds_rd(ds_rd), .nmi_pin_n(nmi_pin_n), .alu_result(alu_result),
    .acc_in(acc_in), .ds_rvalid(ds_rvalid), .nmi_request(nmi_request),
    .carry_flag(carry_flag), .zero_flag(zero_flag), .pc(pc),
    .flag_mode(flag_mode), .accumulator(accumulator),
    .stack_depth(stack_depth)
);

// ### bench/tb_top.sv
// Self-checking bench for the core flow, flags, stack and data map
`include "cpfs_map.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rstn, fetch, branch, jump, call, ret;
    logic return_from_interrupt, instr_boundary, irq_enter, nmi_enter;
    logic carry_we, carry_in, zero_we, acc_we, ds_rd, ds_wr;
    logic nmi_pin_n, ext_stop_en, stop_req;
    logic [7:0] branch_offset, alu_result, acc_in, ds_addr, ds_wdata;
    logic [7:0] rom_win_data, bank_rdata, rd_data;
    logic [11:0] target, vector, win;
    logic [6:0] bk;
    wire [7:0] ds_rdata, bank_wdata, accumulator, pointer_one;
    wire [7:0] pointer_two, short_direct_one, short_direct_second;
    wire [11:0] rom_win_addr, pc;
    wire [5:0] bank_addr;
    wire [1:0] flag_mode;
    wire [2:0] stack_depth;
    wire ds_rvalid, bank_rd, bank_wr, nmi_request, stop_halt;
    wire stop_as_wait, carry_flag, zero_flag;
    int fails, n_compared, cycles;
    cpfs_core u_dut (
        .core_clk(core_clk), .rstn(rstn), .fetch(fetch), .branch(branch),
        .branch_offset(branch_offset), .jump(jump), .call(call),
        .target(target), .ret(ret),
        .return_from_interrupt(return_from_interrupt),
        .instr_boundary(instr_boundary), .irq_enter(irq_enter),
        .nmi_enter(nmi_enter), .vector(vector), .carry_we(carry_we),
        .carry_in(carry_in), .zero_we(zero_we), .alu_result(alu_result),
        .acc_we(acc_we), .acc_in(acc_in), .ds_addr(ds_addr), .ds_rd(ds_rd),
        .ds_wr(ds_wr), .ds_wdata(ds_wdata), .ds_rdata(ds_rdata),
        .ds_rvalid(ds_rvalid), .rom_win_addr(rom_win_addr),
        .rom_win_data(rom_win_data), .bank_addr(bank_addr),
        .bank_rd(bank_rd), .bank_wr(bank_wr), .bank_wdata(bank_wdata),
        .bank_rdata(bank_rdata), .nmi_pin_n(nmi_pin_n),
        .ext_stop_en(ext_stop_en), .stop_req(stop_req),
        .nmi_request(nmi_request), .stop_halt(stop_halt),
        .stop_as_wait(stop_as_wait), .pc(pc), .flag_mode(flag_mode),
        .carry_flag(carry_flag), .zero_flag(zero_flag),
        .accumulator(accumulator), .pointer_one(pointer_one),
        .pointer_two(pointer_two), .short_direct_one(short_direct_one),
        .short_direct_second(short_direct_second),
        .stack_depth(stack_depth)
    );
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails++;
            conclude();
        end
    end
    task conclude;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Outside data is inverted once its sampling cycle has passed
    task rd(input logic [7:0] a, input logic [7:0] ext);
        @(negedge core_clk);
        ds_addr = a;
        ds_rd = 1'b1;
        rom_win_data = ext;
        bank_rdata = ext;
        @(negedge core_clk);
        ds_rd = 1'b0;
        win = rom_win_addr;
        bk = {bank_rd, bank_addr};
        @(negedge core_clk);
        rom_win_data = ~ext;
        bank_rdata = ~ext;
        chk(ds_rvalid, 12'h001);
        rd_data = ds_rdata;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        ds_addr = a;
        ds_wr = 1'b1;
        ds_wdata = d;
        @(negedge core_clk);
        ds_wr = 1'b0;
        bk = {bank_wr, bank_addr};
    endtask
    task t_flow;
        chk(pc, `CPFS_RESET_VECTOR);
        chk(flag_mode, `CPFS_MODE_NMI);
        fetch = 1'b1;
        tick(3);
        fetch = 1'b0;
        chk(pc, 12'h001);
        jump = 1'b1;
        target = 12'h100;
        tick(1);
        jump = 1'b0;
        chk(pc, 12'h100);
        branch = 1'b1;
        branch_offset = 8'h05;
        tick(1);
        chk(pc, 12'h105);
        branch_offset = 8'hFD;
        tick(1);
        branch = 1'b0;
        chk(pc, 12'h102);
    endtask
    task t_stack;
        int i;
        jump = 1'b1;
        target = 12'h200;
        tick(1);
        jump = 1'b0;
        call = 1'b1;
        for (i = 0; i < 7; i++) begin
            target = 12'(12'h300 + i);
            tick(1);
        end
        call = 1'b0;
        tick(1);
        chk(stack_depth, 12'h006);
        chk(pc, 12'h306);
        ret = 1'b1;
        for (i = 5; i >= 0; i--) begin
            tick(1);
            chk(pc, 12'(12'h300 + i));
        end
        tick(1);
        ret = 1'b0;
        chk(pc, 12'h300);
        tick(1);
        chk(stack_depth, 12'h000);
        ret = 1'b1;
        fetch = 1'b1;
        tick(1);
        ret = 1'b0;
        fetch = 1'b0;
        chk(pc, 12'h301);
    endtask
    task t_flags;
        carry_we = 1'b1;
        carry_in = 1'b1;
        zero_we = 1'b1;
        alu_result = 8'h00;
        tick(1);
        chk({carry_flag, zero_flag}, 12'h003);
        carry_we = 1'b0;
        zero_we = 1'b0;
        return_from_interrupt = 1'b1;
        tick(1);
        return_from_interrupt = 1'b0;
        chk(flag_mode, `CPFS_MODE_NORMAL);
        chk({carry_flag, zero_flag}, 12'h000);
        carry_we = 1'b1;
        zero_we = 1'b1;
        alu_result = 8'h05;
        tick(1);
        carry_we = 1'b0;
        zero_we = 1'b0;
        chk({carry_flag, zero_flag}, 12'h002);
        irq_enter = 1'b1;
        vector = 12'hFF6;
        tick(1);
        chk(flag_mode, `CPFS_MODE_NORMAL);
        instr_boundary = 1'b1;
        tick(1);
        irq_enter = 1'b0;
        chk(pc, 12'hFF6);
        chk(flag_mode, `CPFS_MODE_IRQ);
        chk({carry_flag, zero_flag}, 12'h000);
        return_from_interrupt = 1'b1;
        tick(1);
        return_from_interrupt = 1'b0;
        chk(pc, 12'h301);
        chk({flag_mode, carry_flag, zero_flag}, 12'h002);
        nmi_enter = 1'b1;
        vector = 12'hFFC;
        tick(1);
        nmi_enter = 1'b0;
        instr_boundary = 1'b0;
        chk({flag_mode, carry_flag, zero_flag}, 12'h00B);
    endtask
    task t_data;
        int i;
        for (i = 0; i < 4; i++)
            wr(8'(8'h80 + i), 8'(8'hA0 + i));
        wr(8'hFF, 8'h5C);
        wr(8'h90, 8'h3E);
        chk({pointer_one, pointer_two}, 16'hA0A1);
        chk({short_direct_one, short_direct_second}, 16'hA2A3);
        chk(accumulator, 12'h05C);
        acc_we = 1'b1;
        acc_in = 8'hC3;
        tick(1);
        acc_we = 1'b0;
        for (i = 0; i < 4; i++) begin
            rd(8'(8'h80 + i), 8'h00);
            chk(rd_data, 12'(8'hA0 + i));
        end
        rd(8'hFF, 8'h00);
        chk(rd_data, 12'h0C3);
        rd(8'h90, 8'h00);
        chk(rd_data, 12'h03E);
        wr(8'hC9, 8'h03);
        rd(8'h45, 8'h6B);
        chk(win, 12'h0C5);
        chk(rd_data, 12'h06B);
        rd(8'h05, 8'h27);
        chk({bk, rd_data}, 16'h4527);
        wr(8'h3A, 8'h99);
        chk({bk, bank_wdata}, 16'h7A99);
        rd(8'hC0, 8'h11);
        chk(rd_data, 12'h000);
    endtask
    task t_nmi;
        int i;
        int n;
        n = 0;
        nmi_pin_n = 1'b0;
        for (i = 0; i < 20; i++) begin
            tick(1);
            if (nmi_request === 1'b1)
                n++;
        end
        chk(12'(n), 12'h001);
        ext_stop_en = 1'b1;
        stop_req = 1'b1;
        tick(1);
        stop_req = 1'b0;
        chk({stop_halt, stop_as_wait}, 12'h001);
        nmi_pin_n = 1'b1;
        tick(4);
        stop_req = 1'b1;
        tick(1);
        stop_req = 1'b0;
        chk({stop_halt, stop_as_wait}, 12'h002);
    endtask
    initial begin
        core_clk = 1'b0;
        rstn = 1'b0;
        {fetch, branch, jump, call, ret, return_from_interrupt} = '0;
        {instr_boundary, irq_enter, nmi_enter, carry_we, carry_in} = '0;
        {zero_we, acc_we, ds_rd, ds_wr, ext_stop_en, stop_req} = '0;
        {branch_offset, alu_result, acc_in, ds_addr, ds_wdata} = '0;
        {rom_win_data, bank_rdata, target, vector} = '0;
        nmi_pin_n = 1'b1;
        tick(2);
        rstn = 1'b1;
        t_flow();
        t_stack();
        t_flags();
        t_data();
        t_nmi();
        conclude();
    end
endmodule

// ### src/cpfs_core.v
// Program counter, banked flags, return stack and data-space map of the core
// How it works
// - NMI pin is synchronised and requests only on a falling edge.
// - Accumulator is also data-space location FFh, readable and writable.
// - Pointer registers sit at data-space 80h and 81h.
// - Short-direct registers sit at data-space 82h and 83h.
// - Program counter is 12 bits, addressing 4096 program bytes.
// - A fetch with no entry, jump, call, branch or stack pop advances the program counter by one.
// - Relative branch adds signed offset to program counter.
// - PC loads jump/call target, vector, reset vector, or popped stack top.
// - Three carry/zero pairs exist; only the current mode's pair is used.
// - Entry selects irq or NMI pair; return restores previous mode's pair.
// - Mode switches never clear any flag pair.
// - Carry takes arithmetic carry, tested bit, or rotate-left bit.
// - Zero is set when the latest result equals zero.
// - Reset leaves the core in NMI mode using the NMI pair.
// - Push shifts all six levels down, PC enters level one.
// - Return moves level one to PC and shifts levels up.
// - Depth saturates at six; return on empty stack just continues.
// - With external stop control, the NMI level decides stop handling.
// - Static RAM at 80h-BFh; 00h-3Fh is a banked external region.
// - A 64-byte data-space window reads constants from program ROM.
// - ROM window address is window bank bits then six operand bits.
`include "cpfs_map.vh"

module cpfs_core #(
    parameter PC_W = `CPFS_PC_W,
    parameter DATA_W = `CPFS_DATA_W,
    parameter ADDR_W = `CPFS_ADDR_W,
    parameter RAM_DEPTH = `CPFS_RAM_DEPTH
) (
    // Clock and reset
    input wire core_clk,
    input wire rstn,
    // Sequencer program-flow controls
    input wire fetch,
    input wire branch,
    input wire [DATA_W-1:0] branch_offset,
    input wire jump,
    input wire call,
    input wire [PC_W-1:0] target,
    input wire ret,
    input wire return_from_interrupt,
    input wire instr_boundary,
    input wire irq_enter,
    input wire nmi_enter,
    input wire [PC_W-1:0] vector,
    // Flag and accumulator updates from the ALU
    input wire carry_we,
    input wire carry_in,
    input wire zero_we,
    input wire [DATA_W-1:0] alu_result,
    input wire acc_we,
    input wire [DATA_W-1:0] acc_in,
    // Data-space access
    input wire [ADDR_W-1:0] ds_addr,
    input wire ds_rd,
    input wire ds_wr,
    input wire [DATA_W-1:0] ds_wdata,
    output reg [DATA_W-1:0] ds_rdata,
    output reg ds_rvalid,
    // Program ROM constant window
    output reg [PC_W-1:0] rom_win_addr,
    input wire [DATA_W-1:0] rom_win_data,
    // Banked RAM/EEPROM region
    output reg [5:0] bank_addr,
    output reg bank_rd,
    output reg bank_wr,
    output reg [DATA_W-1:0] bank_wdata,
    input wire [DATA_W-1:0] bank_rdata,
    // NMI pin and stop control
    input wire nmi_pin_n,
    input wire ext_stop_en,
    input wire stop_req,
    output reg nmi_request,
    output reg stop_halt,
    output reg stop_as_wait,
    // Programming model state
    output reg [PC_W-1:0] pc,
    output reg [1:0] flag_mode,
    output reg carry_flag,
    output reg zero_flag,
    output reg [DATA_W-1:0] accumulator,
    output reg [DATA_W-1:0] pointer_one,
    output reg [DATA_W-1:0] pointer_two,
    output reg [DATA_W-1:0] short_direct_one,
    output reg [DATA_W-1:0] short_direct_second,
    output reg [2:0] stack_depth
);

    localparam [PC_W-1:0] PC_ONE = {{(PC_W-1){1'b0}}, 1'b1};
    reg nmi_meta;
    reg nmi_sync;
    reg nmi_prev;
    always @(posedge core_clk) begin
        if (!rstn) begin
            nmi_meta <= 1'b1;
            nmi_sync <= 1'b1;
            nmi_prev <= 1'b1;
            nmi_request <= 1'b0;
            stop_halt <= 1'b0;
            stop_as_wait <= 1'b0;
        end else begin
            nmi_meta <= nmi_pin_n;
            nmi_sync <= nmi_meta;
            nmi_prev <= nmi_sync;
            // A held low level gives one request only
            nmi_request <= nmi_prev & ~nmi_sync;
            // Held NMI low turns the stop into a wait under the option
            stop_halt <= stop_req & (~ext_stop_en | nmi_sync);
            stop_as_wait <= stop_req & ext_stop_en & ~nmi_sync;
        end
    end

    wire take_irq;
    wire stack_push;
    wire stack_pop;
    wire [PC_W-1:0] stack_top;
    wire stack_empty;
    wire [2:0] depth_now;
    // Entry requests outside a boundary are ignored
    assign take_irq = instr_boundary & (irq_enter | nmi_enter);
    assign stack_push = take_irq | (call & ~take_irq);
    assign stack_pop = (ret | return_from_interrupt) & ~stack_push;
    cpfs_stack #(
        .PC_W(PC_W),
        .DEPTH(`CPFS_STACK_DEPTH),
        .DEPTH_W(`CPFS_DEPTH_W)
    ) u_stack (
        .core_clk(core_clk),
        .rstn(rstn),
        .push(stack_push),
        .pop(stack_pop),
        .push_value(pc),
        .top(stack_top),
        .empty(stack_empty),
        .depth(depth_now)
    );

    reg [PC_W-1:0] next_pc;
    wire [PC_W-1:0] offset_ext;
    assign offset_ext = {{(PC_W-DATA_W){branch_offset[DATA_W-1]}},
                         branch_offset};
    always @* begin
        next_pc = pc;
        if (take_irq) begin
            next_pc = vector;
        end else if (jump || call) begin
            next_pc = target;
        end else if (branch) begin
            next_pc = pc + offset_ext;
        end else if (ret || return_from_interrupt) begin
            if (!stack_empty) begin
                next_pc = stack_top;
            end else if (fetch) begin
                next_pc = pc + PC_ONE;
            end
        end else if (fetch) begin
            next_pc = pc + PC_ONE;
        end
    end
    always @(posedge core_clk) begin
        if (!rstn) begin
            pc <= `CPFS_RESET_VECTOR;
            stack_depth <= 3'h0;
        end else begin
            pc <= next_pc;
            stack_depth <= depth_now;
        end
    end

    reg [1:0] saved_mode_1;
    reg [1:0] saved_mode_2;
    reg [1:0] next_mode;
    reg [2:0] carry_bank;
    reg [2:0] zero_bank;
    reg [2:0] next_carry_bank;
    reg [2:0] next_zero_bank;
    wire result_zero;
    assign result_zero = (alu_result == {DATA_W{1'b0}});
    always @* begin
        next_mode = flag_mode;
        if (take_irq) begin
            next_mode = nmi_enter ? `CPFS_MODE_NMI : `CPFS_MODE_IRQ;
        end else if (return_from_interrupt) begin
            next_mode = saved_mode_1;
        end
    end
    // Only the active pair is touched; the others keep their values
    always @* begin
        next_carry_bank = carry_bank;
        next_zero_bank = zero_bank;
        if (carry_we) begin
            next_carry_bank[flag_mode] = carry_in;
        end
        if (zero_we) begin
            next_zero_bank[flag_mode] = result_zero;
        end
    end
    always @(posedge core_clk) begin
        if (!rstn) begin
            flag_mode <= `CPFS_MODE_NMI;
            saved_mode_1 <= `CPFS_MODE_NORMAL;
            saved_mode_2 <= `CPFS_MODE_NORMAL;
            carry_bank <= 3'h0;
            zero_bank <= 3'h0;
            carry_flag <= 1'b0;
            zero_flag <= 1'b0;
        end else begin
            flag_mode <= next_mode;
            if (take_irq) begin
                saved_mode_1 <= flag_mode;
                saved_mode_2 <= saved_mode_1;
            end else if (return_from_interrupt) begin
                saved_mode_1 <= saved_mode_2;
                saved_mode_2 <= `CPFS_MODE_NORMAL;
            end
            // No clear on switching: banks only change by writes
            carry_bank <= next_carry_bank;
            zero_bank <= next_zero_bank;
            carry_flag <= next_carry_bank[next_mode];
            zero_flag <= next_zero_bank[next_mode];
        end
    end

    reg [DATA_W-1:0] static_ram [0:RAM_DEPTH-1];
    reg [5:0] rom_window_bank;
    wire [1:0] region;
    wire wr_acc;
    assign region = ds_addr[ADDR_W-1:ADDR_W-2];
    assign wr_acc = ds_wr && (ds_addr == `CPFS_OFS_ACCUMULATOR);
    // ALU load wins over a data-space write in the same cycle
    always @(posedge core_clk) begin
        if (!rstn) begin
            accumulator <= `CPFS_RESET_DATA;
            pointer_one <= `CPFS_RESET_DATA;
            pointer_two <= `CPFS_RESET_DATA;
            short_direct_one <= `CPFS_RESET_DATA;
            short_direct_second <= `CPFS_RESET_DATA;
            rom_window_bank <= `CPFS_RESET_BANK;
        end else begin
            if (acc_we) begin
                accumulator <= acc_in;
            end else if (wr_acc) begin
                accumulator <= ds_wdata;
            end
            if (ds_wr) begin
                if (ds_addr == `CPFS_OFS_POINTER_ONE) begin
                    pointer_one <= ds_wdata;
                end else if (ds_addr == `CPFS_OFS_POINTER_TWO) begin
                    pointer_two <= ds_wdata;
                end else if (ds_addr == `CPFS_OFS_SHORT_DIRECT_ONE) begin
                    short_direct_one <= ds_wdata;
                end else if (ds_addr == `CPFS_OFS_SHORT_DIRECT_SECOND) begin
                    short_direct_second <= ds_wdata;
                end else if (ds_addr == `CPFS_OFS_ROM_WINDOW_BANK) begin
                    // Write-only: software must keep its own image
                    rom_window_bank <= ds_wdata[5:0];
                end
            end
        end
    end
    // Static RAM, no reset; 80h-83h are shadowed by the registers
    always @(posedge core_clk) begin
        if (ds_wr && region == `CPFS_REGION_STATIC_RAM) begin
            static_ram[ds_addr[5:0]] <= ds_wdata;
        end
    end

    reg [ADDR_W-1:0] rd_addr_q;
    reg rd_pend;
    reg [DATA_W-1:0] next_rdata;
    always @(posedge core_clk) begin
        if (!rstn) begin
            rd_addr_q <= {ADDR_W{1'b0}};
            rd_pend <= 1'b0;
            rom_win_addr <= {PC_W{1'b0}};
            bank_addr <= 6'h00;
            bank_rd <= 1'b0;
            bank_wr <= 1'b0;
            bank_wdata <= `CPFS_RESET_DATA;
        end else begin
            rd_pend <= ds_rd;
            bank_rd <= ds_rd && region == `CPFS_REGION_BANKED;
            bank_wr <= ds_wr && region == `CPFS_REGION_BANKED;
            if (ds_rd) begin
                rd_addr_q <= ds_addr;
            end
            if (ds_rd || ds_wr) begin
                bank_addr <= ds_addr[5:0];
            end
            if (ds_wr) begin
                bank_wdata <= ds_wdata;
            end
            if (ds_rd && region == `CPFS_REGION_ROM_WINDOW) begin
                rom_win_addr <= {rom_window_bank,
                    ds_addr[`CPFS_WINDOW_LOW_W-1:0]};
            end
        end
    end
    // Unmapped and write-only locations read as zero
    always @* begin
        next_rdata = `CPFS_RESET_DATA;
        if (rd_addr_q == `CPFS_OFS_POINTER_ONE) begin
            next_rdata = pointer_one;
        end else if (rd_addr_q == `CPFS_OFS_POINTER_TWO) begin
            next_rdata = pointer_two;
        end else if (rd_addr_q == `CPFS_OFS_SHORT_DIRECT_ONE) begin
            next_rdata = short_direct_one;
        end else if (rd_addr_q == `CPFS_OFS_SHORT_DIRECT_SECOND) begin
            next_rdata = short_direct_second;
        end else if (rd_addr_q == `CPFS_OFS_ACCUMULATOR) begin
            next_rdata = accumulator;
        end else if (rd_addr_q[7:6] == `CPFS_REGION_STATIC_RAM) begin
            next_rdata = static_ram[rd_addr_q[5:0]];
        end else if (rd_addr_q[7:6] == `CPFS_REGION_ROM_WINDOW) begin
            next_rdata = rom_win_data;
        end else if (rd_addr_q[7:6] == `CPFS_REGION_BANKED) begin
            next_rdata = bank_rdata;
        end
    end
    always @(posedge core_clk) begin
        if (!rstn) begin
            ds_rdata <= `CPFS_RESET_DATA;
            ds_rvalid <= 1'b0;
        end else begin
            ds_rvalid <= rd_pend;
            if (rd_pend) begin
                ds_rdata <= next_rdata;
            end
        end
    end

endmodule

// ### src/cpfs_map.vh
// Constants for the program counter, flag and return stack core block
`ifndef CPFS_MAP_VH
`define CPFS_MAP_VH

// Widths
`define CPFS_PC_W 12
`define CPFS_DATA_W 8
`define CPFS_ADDR_W 8
`define CPFS_STACK_DEPTH 6
`define CPFS_DEPTH_W 3

// Data-space register offsets
`define CPFS_OFS_POINTER_ONE 8'h80
`define CPFS_OFS_POINTER_TWO 8'h81
`define CPFS_OFS_SHORT_DIRECT_ONE 8'h82
`define CPFS_OFS_SHORT_DIRECT_SECOND 8'h83
`define CPFS_OFS_ACCUMULATOR 8'hFF
`define CPFS_OFS_ROM_WINDOW_BANK 8'hC9

// Data-space regions, top two address bits
`define CPFS_REGION_BANKED 2'h0
`define CPFS_REGION_ROM_WINDOW 2'h1
`define CPFS_REGION_STATIC_RAM 2'h2
`define CPFS_WINDOW_LOW_W 6
`define CPFS_RAM_DEPTH 64

// Flag modes
`define CPFS_MODE_NORMAL 2'h0
`define CPFS_MODE_IRQ 2'h1
`define CPFS_MODE_NMI 2'h2

// Reset values
`define CPFS_RESET_VECTOR 12'hFFE
`define CPFS_RESET_DATA 8'h00
`define CPFS_RESET_BANK 6'h00

`endif

// ### src/cpfs_stack.v
// Six-level shift-register return stack without a stack pointer
`include "cpfs_map.vh"

module cpfs_stack #(
    parameter PC_W = `CPFS_PC_W,
    parameter DEPTH = `CPFS_STACK_DEPTH,
    parameter DEPTH_W = `CPFS_DEPTH_W
) (
    // Clock and reset
    input wire core_clk,
    input wire rstn,
    // Stack operations
    input wire push,
    input wire pop,
    input wire [PC_W-1:0] push_value,
    // State
    output wire [PC_W-1:0] top,
    output wire empty,
    output reg [DEPTH_W-1:0] depth
);

    reg [PC_W-1:0] level [0:DEPTH-1];

    assign top = level[0];
    assign empty = (depth == {DEPTH_W{1'b0}});

    // Level one takes the pushed value; the deepest value falls off
    always @(posedge core_clk) begin
        if (push) begin
            level[0] <= push_value;
        end else if (pop && !empty) begin
            level[0] <= level[1];
        end
    end

    genvar i;
    generate
        for (i = 1; i < DEPTH; i = i + 1) begin : g_level
            always @(posedge core_clk) begin
                if (push) begin
                    level[i] <= level[i-1];
                end else if (pop && !empty) begin
                    if (i == DEPTH - 1) begin
                        level[i] <= {PC_W{1'b0}};
                    end else begin
                        level[i] <= level[i+1];
                    end
                end
            end
        end
    endgenerate

    // Depth saturates both ways rather than wrapping
    always @(posedge core_clk) begin
        if (!rstn) begin
            depth <= {DEPTH_W{1'b0}};
        end else if (push) begin
            if (depth != DEPTH[DEPTH_W-1:0]) begin
                depth <= depth + {{(DEPTH_W-1){1'b0}}, 1'b1};
            end
        end else if (pop && !empty) begin
            depth <= depth - {{(DEPTH_W-1){1'b0}}, 1'b1};
        end
    end

endmodule
